// *** logic/cb_attr_pkg.sv ***
// Purpose: Constants for the context bank attribute decoder
// Assumes: One 32-bit AXI4-Lite register word per bank
// Notes:   Offsets are byte addresses
package cb_attr_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] ATTR_BASE_OFS   = 12'h000;
   localparam logic [11:0] CTRL_OFS        = 12'h100;
   localparam logic [11:0] STATUS_OFS      = 12'h104;
   localparam logic [31:0] ATTR_RESET      = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   // ----------------------------------------
   // Attribute field positions
   // ----------------------------------------
   localparam int IRQ_LSB       = 24;
   localparam int IRQ_MSB       = 31;
   localparam int TYPE_LSB      = 16;
   localparam int TYPE_MSB      = 17;
   localparam int S2IDX_LSB     = 8;
   localparam int S2IDX_MSB     = 15;
   localparam int BCAST_BIT     = 11;
   localparam int HYPX_BIT      = 10;
   localparam int BPSH_LSB      = 8;
   localparam int BPSH_MSB      = 9;
   localparam int VM_LSB        = 0;
   localparam int VM_MSB        = 7;
   // Control register bits
   localparam int CTRL_HYP_MODE = 0;
   localparam int CTRL_WIDEVM   = 1;
   localparam int CTRL_ALIAS    = 2;
   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [1:0] TYPE_S2       = 2'h0;
   localparam logic [1:0] TYPE_S1_BYP   = 2'h1;
   localparam logic [1:0] TYPE_S1_FAULT = 2'h2;
   localparam logic [1:0] TYPE_NESTED   = 2'h3;
   localparam logic [1:0] SH_RSVD       = 2'h0;
   localparam logic [1:0] SH_OUTER      = 2'h1;
   localparam logic [1:0] SH_INNER      = 2'h2;
   localparam logic [1:0] SH_NONE       = 2'h3;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   typedef enum logic [2:0] {
      BUS_IDLE  = 3'h1,
      BUS_WRESP = 3'h2,
      BUS_RRESP = 3'h4
   } bus_state_type;
endpackage

// *** logic/context_bank_attribute_decode.sv ***
// Purpose: Per-bank attribute register file and decode for stage-1 contexts
// Assumes: Software programs banks over AXI4-Lite; datapath looks up one bank
// Notes:   One bus access handled at a time; answers one cycle after acceptance
//
// Operation
// - Force-broadcast upgrades maintenance to inner-shareable
// - Bit 10 is hyp enable otherwise
// - Hyp context: no address or VM tag
// - Bit 10 is host-ext enable when selected
// - Host-ext tags non-global entries with address tag
// - Bypass shareability encodes outer, inner, none
// - Stronger of stage-1 and bypass shareability wins
// - No bypass support: field reads zero
// - Narrow VM tag unless wide tags enabled
// - Secure bank VM tag ignored when unsupported
// - Type fault-only raises invalid context fault
// - Top byte holds context interrupt index
// - Nested type holds stage-2 bank index; index bits 9:8 are writable only with bypass support
// - Unimplemented index bits read zero, except bit 11 (force-broadcast)
// - Two-bit type selects translation arrangement
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module context_bank_attribute_decode #(
   parameter int          NUM_BANKS     = 8,
   parameter int          IDX_W         = 3,
   parameter bit          HOST_EXT_SUPP = 1'b1,
   parameter bit          BYPASS_SUPP   = 1'b1,
   parameter bit          SECURE_VM_SUPP = 1'b0
) (
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // AXI4-Lite slave
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Datapath lookup
   input  wire logic [IDX_W-1:0]  lk_bank,
   input  wire logic              lk_secure,
   input  wire logic [1:0]        lk_s1_share,
   input  wire logic              lk_maint_op,
   input  wire logic              lk_maint_is,
   output logic                   lk_maint_bcast,
   output logic [1:0]             lk_type,
   output logic                   lk_ctx_fault,
   output logic                   lk_hyp_ctx,
   output logic                   lk_host_ext_ctx,
   output logic                   lk_use_addr_space_tag,
   output logic                   lk_use_vm_tag,
   output logic                   lk_addr_tag_nonglobal_only,
   output logic [7:0]             lk_vm_tag,
   output logic [1:0]             lk_share,
   output logic [7:0]             lk_irq_index,
   output logic [IDX_W-1:0]       lk_s2_bank,
   output logic                   lk_nested
);
   // ----------------------------------------
   // Bus state
   // ----------------------------------------
   cb_attr_pkg::bus_state_type st_q, st_d;
   logic [31:0]                 attr_q [NUM_BANKS];
   logic [31:0]                 attr_d [NUM_BANKS];
   logic [31:0]                 ctrl_q, ctrl_d;
   logic [31:0]                 rdata_q, rdata_d;
   logic [1:0]                  resp_q, resp_d;
   logic                        do_wr, do_rd;
   logic [11:0]                 rel_w, rel_r;
   logic                        w_hit, r_hit;
   logic [IDX_W-1:0]            w_bank, r_bank;
   logic [31:0]                 wmask;
   logic [31:0]                 attr_keep;

   // Write address and data are taken together in the same edge
   assign s_axi_awready = (st_q == cb_attr_pkg::BUS_IDLE) && s_axi_awvalid && s_axi_wvalid;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = (st_q == cb_attr_pkg::BUS_IDLE) && !s_axi_awready;
   assign do_wr         = s_axi_awready;
   assign do_rd         = s_axi_arready && s_axi_arvalid;
   assign s_axi_bvalid  = (st_q == cb_attr_pkg::BUS_WRESP);
   assign s_axi_rvalid  = (st_q == cb_attr_pkg::BUS_RRESP);
   assign s_axi_bresp   = resp_q;
   assign s_axi_rresp   = resp_q;
   assign s_axi_rdata   = rdata_q;

   assign rel_w  = s_axi_awaddr - cb_attr_pkg::ATTR_BASE_OFS;
   assign rel_r  = s_axi_araddr - cb_attr_pkg::ATTR_BASE_OFS;
   assign w_bank = rel_w[IDX_W+1:2];
   assign r_bank = rel_r[IDX_W+1:2];
   assign w_hit  = (rel_w[11:2] < 10'(NUM_BANKS));
   assign r_hit  = (rel_r[11:2] < 10'(NUM_BANKS));

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{s_axi_wstrb[b]}};
      end
   end

   // Writable bits: reserved bits and unimplemented index bits other than bit 11 (force-broadcast) stay zero
   always_comb begin
      attr_keep = 32'h0000_0000;
      attr_keep[cb_attr_pkg::IRQ_MSB:cb_attr_pkg::IRQ_LSB]   = 8'hff;
      attr_keep[cb_attr_pkg::TYPE_MSB:cb_attr_pkg::TYPE_LSB] = 2'h3;
      attr_keep[cb_attr_pkg::BCAST_BIT]                      = 1'b1;
      attr_keep[cb_attr_pkg::HYPX_BIT]                       = 1'b1;
      attr_keep[cb_attr_pkg::S2IDX_LSB +: IDX_W]             = {IDX_W{1'b1}};
      attr_keep[cb_attr_pkg::VM_MSB:cb_attr_pkg::VM_LSB]     = 8'hff;
      if (BYPASS_SUPP) begin
         attr_keep[cb_attr_pkg::BPSH_MSB:cb_attr_pkg::BPSH_LSB] = 2'h3;
      end else begin
         attr_keep[cb_attr_pkg::BPSH_MSB:cb_attr_pkg::BPSH_LSB] = 2'h0;
      end
   end

   always_comb begin
      st_d    = st_q;
      ctrl_d  = ctrl_q;
      rdata_d = rdata_q;
      resp_d  = resp_q;
      for (int i = 0; i < NUM_BANKS; i++) begin
         attr_d[i] = attr_q[i];
      end
      case (st_q)
         cb_attr_pkg::BUS_IDLE: begin
            if (do_wr) begin
               st_d   = cb_attr_pkg::BUS_WRESP;
               resp_d = cb_attr_pkg::RESP_OKAY;
               if (w_hit) begin
                  attr_d[w_bank] = ((attr_q[w_bank] & ~wmask) | (s_axi_wdata & wmask)) & attr_keep;
               end else if (s_axi_awaddr == cb_attr_pkg::CTRL_OFS) begin
                  ctrl_d = ((ctrl_q & ~wmask) | (s_axi_wdata & wmask)) & 32'h0000_0007;
               end else if (s_axi_awaddr != cb_attr_pkg::STATUS_OFS) begin
                  resp_d = cb_attr_pkg::RESP_SLVERR;
               end
            end else if (do_rd) begin
               st_d    = cb_attr_pkg::BUS_RRESP;
               resp_d  = cb_attr_pkg::RESP_OKAY;
               rdata_d = 32'h0000_0000;
               if (r_hit) begin
                  rdata_d = attr_q[r_bank];
               end else if (s_axi_araddr == cb_attr_pkg::CTRL_OFS) begin
                  rdata_d = ctrl_q;
               end else if (s_axi_araddr == cb_attr_pkg::STATUS_OFS) begin
                  rdata_d = {29'h0, lk_ctx_fault, lk_host_ext_ctx, lk_hyp_ctx};
               end else begin
                  resp_d = cb_attr_pkg::RESP_SLVERR;
               end
            end
         end
         cb_attr_pkg::BUS_WRESP: begin
            if (s_axi_bready) begin
               st_d = cb_attr_pkg::BUS_IDLE;
            end
         end
         cb_attr_pkg::BUS_RRESP: begin
            if (s_axi_rready) begin
               st_d = cb_attr_pkg::BUS_IDLE;
            end
         end
         default: begin
            st_d = cb_attr_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q    <= cb_attr_pkg::BUS_IDLE;
         ctrl_q  <= cb_attr_pkg::CTRL_RESET;
         rdata_q <= 32'h0000_0000;
         resp_q  <= cb_attr_pkg::RESP_OKAY;
         for (int i = 0; i < NUM_BANKS; i++) begin
            attr_q[i] <= cb_attr_pkg::ATTR_RESET;
         end
      end else begin
         st_q    <= st_d;
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
         for (int i = 0; i < NUM_BANKS; i++) begin
            attr_q[i] <= attr_d[i];
         end
      end
   end

   // ----------------------------------------
   // Attribute decode
   // ----------------------------------------
   // Results are registered: the datapath sees a lookup one edge after it
   // presents the bank, which keeps the bank mux off the datapath's timing
   logic [31:0]      cur;
   logic [1:0]       ctype;
   logic             host_ext_mode;
   logic             bit10;
   logic [1:0]       byp;
   logic             s1_type;
   logic             maint_bcast_d, maint_bcast_q;
   logic [1:0]       type_d, type_q;
   logic             ctx_fault_d, ctx_fault_q;
   logic             hyp_ctx_d, hyp_ctx_q;
   logic             host_ext_ctx_d, host_ext_ctx_q;
   logic             use_addr_tag_d, use_addr_tag_q;
   logic             nonglobal_d, nonglobal_q;
   logic             use_vm_tag_d, use_vm_tag_q;
   logic [7:0]       vm_tag_d, vm_tag_q;
   logic [1:0]       share_d, share_q;
   logic [7:0]       irq_index_d, irq_index_q;
   logic [IDX_W-1:0] s2_bank_d, s2_bank_q;
   logic             nested_d, nested_q;

   assign cur           = attr_q[lk_bank];
   assign ctype         = cur[cb_attr_pkg::TYPE_MSB:cb_attr_pkg::TYPE_LSB];
   assign bit10         = cur[cb_attr_pkg::HYPX_BIT];
   assign host_ext_mode = HOST_EXT_SUPP && ctrl_q[cb_attr_pkg::CTRL_HYP_MODE];
   assign byp           = cur[cb_attr_pkg::BPSH_MSB:cb_attr_pkg::BPSH_LSB];
   assign s1_type       = (ctype != cb_attr_pkg::TYPE_S2);

   always_comb begin
      type_d         = ctype;
      ctx_fault_d    = (ctype == cb_attr_pkg::TYPE_S1_FAULT);
      nested_d       = (ctype == cb_attr_pkg::TYPE_NESTED);
      s2_bank_d      = nested_d ? cur[cb_attr_pkg::S2IDX_LSB +: IDX_W] : '0;
      irq_index_d    = cur[cb_attr_pkg::IRQ_MSB:cb_attr_pkg::IRQ_LSB];
      maint_bcast_d  = lk_maint_op && (lk_maint_is ||
                       (ctype == cb_attr_pkg::TYPE_S1_BYP && cur[cb_attr_pkg::BCAST_BIT]));
      hyp_ctx_d      = (ctype == cb_attr_pkg::TYPE_S1_BYP) && !host_ext_mode && bit10;
      host_ext_ctx_d = (ctype == cb_attr_pkg::TYPE_S1_BYP) && host_ext_mode && bit10;
      use_addr_tag_d = s1_type && !hyp_ctx_d;
      nonglobal_d    = host_ext_ctx_d;
      use_vm_tag_d   = !hyp_ctx_d && !host_ext_ctx_d && !ctx_fault_d &&
                       !(lk_secure && !SECURE_VM_SUPP);
      if (ctrl_q[cb_attr_pkg::CTRL_WIDEVM] || !use_vm_tag_d) begin
         vm_tag_d = 8'h00;
      end else begin
         vm_tag_d = cur[cb_attr_pkg::VM_MSB:cb_attr_pkg::VM_LSB];
      end
      // Stronger shareability wins; reserved or unsupported bypass adds nothing
      share_d = lk_s1_share;
      if (ctype == cb_attr_pkg::TYPE_S1_BYP && BYPASS_SUPP && byp != cb_attr_pkg::SH_RSVD) begin
         if (lk_s1_share == cb_attr_pkg::SH_OUTER || byp == cb_attr_pkg::SH_OUTER) begin
            share_d = cb_attr_pkg::SH_OUTER;
         end else if (lk_s1_share == cb_attr_pkg::SH_INNER || byp == cb_attr_pkg::SH_INNER) begin
            share_d = cb_attr_pkg::SH_INNER;
         end else begin
            share_d = cb_attr_pkg::SH_NONE;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         maint_bcast_q  <= 1'h0;
         type_q         <= cb_attr_pkg::TYPE_S2;
         ctx_fault_q    <= 1'h0;
         hyp_ctx_q      <= 1'h0;
         host_ext_ctx_q <= 1'h0;
         use_addr_tag_q <= 1'h0;
         nonglobal_q    <= 1'h0;
         use_vm_tag_q   <= 1'h0;
         vm_tag_q       <= 8'h00;
         share_q        <= cb_attr_pkg::SH_RSVD;
         irq_index_q    <= 8'h00;
         s2_bank_q      <= '0;
         nested_q       <= 1'h0;
      end else begin
         maint_bcast_q  <= maint_bcast_d;
         type_q         <= type_d;
         ctx_fault_q    <= ctx_fault_d;
         hyp_ctx_q      <= hyp_ctx_d;
         host_ext_ctx_q <= host_ext_ctx_d;
         use_addr_tag_q <= use_addr_tag_d;
         nonglobal_q    <= nonglobal_d;
         use_vm_tag_q   <= use_vm_tag_d;
         vm_tag_q       <= vm_tag_d;
         share_q        <= share_d;
         irq_index_q    <= irq_index_d;
         s2_bank_q      <= s2_bank_d;
         nested_q       <= nested_d;
      end
   end

   assign lk_maint_bcast             = maint_bcast_q;
   assign lk_type                    = type_q;
   assign lk_ctx_fault               = ctx_fault_q;
   assign lk_hyp_ctx                 = hyp_ctx_q;
   assign lk_host_ext_ctx            = host_ext_ctx_q;
   assign lk_use_addr_space_tag      = use_addr_tag_q;
   assign lk_addr_tag_nonglobal_only = nonglobal_q;
   assign lk_use_vm_tag              = use_vm_tag_q;
   assign lk_vm_tag                  = vm_tag_q;
   assign lk_share                   = share_q;
   assign lk_irq_index               = irq_index_q;
   assign lk_s2_bank                 = s2_bank_q;
   assign lk_nested                  = nested_q;
endmodule

// *** tb/context_bank_attribute_decode_bench.sv ***
// Purpose: Self-checking bench for the context bank attribute decoder
// Assumes: Default parameters: eight banks, three index bits
// Notes:   A copy of every register word predicts reads and lookups
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module context_bank_attribute_decode_bench;
   logic        clk_sys = 1'h0;
   logic        rstn = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, lk_secure = 1'h0, lk_maint_op = 1'h0, lk_maint_is = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lk_nested;
   logic        lk_maint_bcast, lk_ctx_fault, lk_hyp_ctx, lk_host_ext_ctx, lk_use_addr_space_tag, lk_use_vm_tag;
   logic        lk_addr_tag_nonglobal_only;
   logic [1:0]  s_axi_bresp, s_axi_rresp, lk_type, lk_share;
   logic [1:0]  lk_s1_share = 2'h1;
   logic [2:0]  lk_bank = 3'h0, lk_s2_bank;
   logic [7:0]  lk_vm_tag, lk_irq_index;
   logic [31:0] attr [8];
   logic [31:0] ctrl, r, seed = 32'ha7f7098d;
   int          num_errors = 0, tests_run = 0, cycles = 0;

   context_bank_attribute_decode i_dut (.*);

   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         test_done();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic test_done();
      if (num_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Bus and lookup drivers
   // ----------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do @(posedge clk_sys); while ((s_axi_awready & s_axi_wready) !== 1'h1);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
      `CHK(s_axi_bresp, er)
      s_axi_bready <= 1'h0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, er)
      s_axi_rready <= 1'h0;
   endtask

   task automatic look(input logic [2:0] b);
      logic [31:0] a;
      logic [1:0]  t;
      logic [1:0]  sh;
      logic        hyp;
      logic        host;
      r = rnd();
      a = attr[b];
      t = a[17:16];
      @(posedge clk_sys);
      lk_bank <= b;
      // A hypervisor bank only sits on the side its alias setting allows
      lk_secure <= (t == 2'h1 && a[10] && !ctrl[0]) ? ctrl[2] : r[0];
      lk_maint_op <= r[1];
      lk_maint_is <= r[2];
      lk_s1_share <= 2'h1 + 2'(r[5:4] % 3);
      // Decoded results are registered, so look one edge later
      @(posedge clk_sys);
      #2;
      hyp = t == 2'h1 && a[10] && !ctrl[0];
      host = t == 2'h1 && a[10] && ctrl[0];
      // Smaller code is the stronger domain; reserved bypass code leaves stage 1
      sh = (t == 2'h1 && a[9:8] != 2'h0 && a[9:8] < lk_s1_share) ? a[9:8] : lk_s1_share;
      `CHK(lk_type, t)
      `CHK(lk_ctx_fault, t == 2'h2)
      `CHK(lk_nested, t == 2'h3)
      `CHK(lk_irq_index, a[31:24])
      `CHK(lk_s2_bank, (t == 2'h3) ? a[10:8] : 3'h0)
      `CHK(lk_maint_bcast, lk_maint_op && (lk_maint_is || t == 2'h1 && a[11]))
      `CHK(lk_hyp_ctx, hyp)
      `CHK(lk_host_ext_ctx, host)
      `CHK(lk_share, sh)
      `CHK(lk_vm_tag, (ctrl[1] || hyp || host || t == 2'h2 || lk_secure) ? 8'h0 : a[7:0])
      `CHK(lk_use_addr_space_tag, t != 2'h0 && !hyp)
      `CHK(lk_addr_tag_nonglobal_only, host)
      `CHK(lk_use_vm_tag, !hyp && !host && t != 2'h2 && !lk_secure)
      rdc(cb_attr_pkg::STATUS_OFS, {29'h0, t == 2'h2, host, hyp}, cb_attr_pkg::RESP_OKAY);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [2:0]  b;
      logic [31:0] d;
      ctrl = 32'h0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         attr[i] = 32'h0;
         rdc(12'(4 * i), cb_attr_pkg::ATTR_RESET, cb_attr_pkg::RESP_OKAY);
      end
      for (int n = 0; n < 64; n++) begin
         r = rnd();
         b = r[2:0];
         if (r[3]) begin
            d = rnd();
            wr(cb_attr_pkg::CTRL_OFS, d, 4'hf, cb_attr_pkg::RESP_OKAY);
            ctrl = d & 32'h7;
            rdc(cb_attr_pkg::CTRL_OFS, ctrl, cb_attr_pkg::RESP_OKAY);
         end
         d = rnd();
         r = rnd();
         // Interrupt index kept below an assumed count of eight
         d[31:24] = {5'h0, d[26:24]};
         wr(12'(4 * b), d, r[3:0], cb_attr_pkg::RESP_OKAY);
         for (int k = 0; k < 4; k++)
            if (r[k]) attr[b][8 * k +: 8] = d[8 * k +: 8];
         // Reserved bits never hold a value
         attr[b] = attr[b] & 32'hff030fff;
         rdc(12'(4 * b), attr[b], cb_attr_pkg::RESP_OKAY);
         look(b);
         look(r[10:8]);
      end
      // Nested bank 6 names stage-2 bank 7, both with the same tag
      wr(12'h01c, 32'h0000_005a, 4'hf, cb_attr_pkg::RESP_OKAY);
      wr(12'h018, 32'h0003_075a, 4'hf, cb_attr_pkg::RESP_OKAY);
      attr[7] = 32'h0000_005a;
      attr[6] = 32'h0003_075a;
      look(3'h6);
      look(3'h7);
      wr(12'h200, rnd(), 4'hf, cb_attr_pkg::RESP_SLVERR);
      rdc(12'h200, 32'h0, cb_attr_pkg::RESP_SLVERR);
      rdc(12'h020, 32'h0, cb_attr_pkg::RESP_SLVERR);
      test_done();
   end
endmodule

// *** tb/context_bank_attribute_decode_properties.sv ***
// Purpose: Concurrent checks on lookup decode and bus answers
// Assumes: Sees only ports of the decoder top module
// Notes:   Lookup outputs are registered; broadcast follows its inputs by one edge
`timescale 1ns/10ps
module context_bank_attribute_decode_properties (
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       lk_maint_op,
   input wire logic       lk_maint_is,
   input wire logic       lk_maint_bcast,
   input wire logic [1:0] lk_type,
   input wire logic       lk_ctx_fault,
   input wire logic       lk_hyp_ctx,
   input wire logic       lk_host_ext_ctx,
   input wire logic       lk_use_addr_space_tag,
   input wire logic       lk_use_vm_tag,
   input wire logic       lk_addr_tag_nonglobal_only
);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_fault_type: assert property (lk_ctx_fault == (lk_type == 2'h2))
      else $error("fault flag disagrees with type");
   a_bcast_kept: assert property (lk_maint_op && lk_maint_is |=> lk_maint_bcast)
      else $error("broadcast op lost");
   a_bcast_idle: assert property (!lk_maint_op |=> !lk_maint_bcast)
      else $error("broadcast without op");
   a_hyp_untagged: assert property (lk_hyp_ctx |-> !lk_use_addr_space_tag && !lk_use_vm_tag)
      else $error("hyp context tagged");
   a_host_addr_tag: assert property (lk_host_ext_ctx |-> lk_addr_tag_nonglobal_only)
      else $error("host-ext context lacks address tag");
   a_ctx_single: assert property (lk_hyp_ctx || lk_host_ext_ctx |->
      lk_type == 2'h1 && !(lk_hyp_ctx && lk_host_ext_ctx))
      else $error("context kind wrong");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write answer late");
   a_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not dropped");
endmodule

bind context_bank_attribute_decode context_bank_attribute_decode_properties i_props (.*);
